/* rtl/ebu_regs.svh */
`ifndef EBU_REGS_SVH
`define EBU_REGS_SVH

// Address areas seen by the bus unit.
`define EBU_IO_AREA_TOP 3'h1
`define EBU_PB_SEGMENT 8'h20
`define EBU_PB_CAN_TOP 2'h0
`define EBU_PB_SER_TOP 3'h2
`define EBU_PB_ALT_TOP 2'h2

// Function configuration field positions.
`define EBU_FC_MUX 0
`define EBU_FC_WIDE 1
`define EBU_FC_CS_EN 2
`define EBU_FC_RDY_EN 3
`define EBU_FC_RDY_POL 4
`define EBU_FC_WIN_EN 5

// Address width limits.
`define EBU_ADDR_MAX 5'h18
`define EBU_SEG_BASE 5'h10

// Reset values.
`define EBU_RESET_DATA 16'h0000
`define EBU_RESET_CS 5'h1F

`endif

/* rtl/ebu_pkg.sv */
package ebu_pkg;
	typedef logic [23:0] ebu_addr_t;
	typedef logic [15:0] ebu_data_t;
	typedef logic [5:0] ebu_fcfg_t;
	typedef logic [3:0] ebu_tcfg_t;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_CMD,
		ST_HOLD,
		ST_PB
	} ebu_state_t;
endpackage : ebu_pkg

/* rtl/ebu_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module ebu_sync (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Level
	input wire logic d_in,
	output logic q_out
);
	logic meta_r;
	logic sync_r;

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end
		else
		begin
			meta_r <= d_in;
			sync_r <= meta_r;
		end
	end

	assign q_out = sync_r;
endmodule : ebu_sync
`default_nettype wire

/* rtl/ebu_win_match.sv */
`timescale 1ns/10ps
`default_nettype none
module ebu_win_match (
	// Window setting
	input wire logic [15:0] sel_in,
	input wire logic en_in,
	// Address
	input wire logic [11:0] addr_hi_in,
	output logic hit_out
);
	wire [3:0] size_code = sel_in[3:0];
	wire [11:0] base = sel_in[15:4];
	wire [11:0] low_ones = (12'h001 << size_code) - 12'h001;
	wire [11:0] cmp_mask = (size_code > 4'hB) ? 12'h000 : ~low_ones;

	assign hit_out = en_in && (((addr_hi_in ^ base) & cmp_mask) == 12'h000);
endmodule : ebu_win_match
`default_nettype wire

/* rtl/ebu_external_bus_unit.sv */
// Operation
// - Single-chip mode: no external bus activity; external requests end in error.
// - Driven address bits programmable from zero to twenty-three.
// - External data bus is eight or sixteen bits wide.
// - Shared address/data ports; demultiplexed modes add dedicated low address port.
// - Active segment lines selectable, limiting space to 8 Mbytes down to 64 Kbytes.
// - Active-low chip selects, one per window plus default.
// - Per-window timing and function settings shape each access.
// - Ready input extends accesses; its active level is selectable.
// - Up to four independently programmable address windows.
// - Window four beats three, window two beats one.
// - Addresses outside all windows use the default settings.
// - The selected window drives its chip select.
// - Bus signals change on the rising edge of the reference clock.
// - Width and multiplexing switch per access with the selected window.
// - Peripheral bus accesses are served on the peripheral bus, also in single-chip mode.
// - I/O area accesses are strictly ordered and never completed early.
// - Reference clock pin carries the system clock divided by two with its fast pad enabled.
`include "ebu_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module ebu_external_bus_unit (
	// Clock and reset
	input wire logic REF_CLK_IN,
	input wire logic RST_N_IN,
	// Configuration
	input wire logic SINGLE_CHIP_IN,
	input wire logic [4:0] ADDR_WIDTH_IN,
	input wire logic [2:0] SEG_LINES_IN,
	input wire logic EXTERNAL_CLOCK_OUTPUT_SELECT_IN,
	input wire logic [4:1][15:0] WINDOW_ADDRESS_SELECT_IN,
	input wire logic [4:1][5:0] WINDOW_FUNCTION_CONFIG_IN,
	input wire logic [4:1][3:0] WINDOW_TIMING_CONFIG_IN,
	input wire ebu_pkg::ebu_fcfg_t DEFAULT_FUNCTION_CONFIG_IN,
	input wire ebu_pkg::ebu_tcfg_t DEFAULT_TIMING_CONFIG_IN,
	// Request
	input wire logic REQ_VALID_IN,
	output logic REQ_READY_OUT,
	input wire ebu_pkg::ebu_addr_t REQ_ADDR_IN,
	input wire logic REQ_WRITE_IN,
	input wire logic REQ_WORD_IN,
	input wire ebu_pkg::ebu_data_t REQ_WDATA_IN,
	// Response
	output logic RSP_VALID_OUT,
	output ebu_pkg::ebu_data_t RSP_RDATA_OUT,
	output logic RSP_ERR_OUT,
	// Peripheral bus
	output logic PB_SEL_OUT,
	output logic PB_WRITE_OUT,
	output logic PB_WORD_OUT,
	output logic [15:0] PB_ADDR_OUT,
	output ebu_pkg::ebu_data_t PB_WDATA_OUT,
	input wire ebu_pkg::ebu_data_t PB_RDATA_IN,
	input wire logic PB_READY_IN,
	// External bus pins
	input wire logic [15:0] AD_IN,
	output logic [15:0] AD_OUT,
	output logic [15:0] AD_OE_OUT,
	output logic [15:0] A_LO_OUT,
	output logic A_LO_OE_OUT,
	output logic [7:0] A_HI_OUT,
	output logic [7:0] A_HI_OE_OUT,
	output logic ALE_OUT,
	output logic RD_N_OUT,
	output logic WR_N_OUT,
	output logic BHE_N_OUT,
	output logic [4:0] CS_N_OUT,
	input wire logic READY_IN,
	output logic BUS_REFERENCE_CLOCK_OUT,
	output logic CLOCK_PAD_ENABLE_OUT,
	// Status
	output logic BUS_BUSY_OUT,
	output logic [2:0] ACTIVE_WINDOW_OUT
);
	import ebu_pkg::*;

	logic [1:0] rst_sync_r;
	logic rst_n;
	logic ref_clk_r;
	logic ready_s;
	ebu_state_t state_r, state_nxt;
	ebu_addr_t addr_r;
	ebu_data_t wdata_r;
	ebu_data_t rdata_r;
	logic write_r, word_r, io_r, second_r;
	logic [2:0] win_r;
	ebu_fcfg_t fcfg_r;
	ebu_tcfg_t tcfg_r;
	logic [3:0] wcnt_r;
	logic rsp_valid_r, rsp_err_r;
	logic [15:0] ad_r, ad_oe_r, a_lo_r;
	logic [7:0] a_hi_r, a_hi_oe_r;
	logic a_lo_oe_r, ale_r, rd_n_r, wr_n_r, bhe_n_r;
	logic [4:0] cs_n_r;
	logic [4:1] win_hit;
	logic [23:0] addr_mask;

	// Reset release through two flip-flops.
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	ebu_sync u_ready_sync (
		.clk_in(REF_CLK_IN),
		.rst_n_in(rst_n),
		.d_in(READY_IN),
		.q_out(ready_s)
	);

	// Window decode of the incoming address.
	genvar gi;
	generate
		for (gi = 1; gi <= 4; gi++)
		begin : g_win
			ebu_win_match u_match (
				.sel_in(WINDOW_ADDRESS_SELECT_IN[gi]),
				.en_in(WINDOW_FUNCTION_CONFIG_IN[gi][`EBU_FC_WIN_EN]),
				.addr_hi_in(REQ_ADDR_IN[23:12]),
				.hit_out(win_hit[gi])
			);
		end
	endgenerate

	wire [2:0] win_sel = win_hit[4] ? 3'h4 : win_hit[3] ? 3'h3 : win_hit[2] ? 3'h2 : win_hit[1] ? 3'h1 : 3'h0;
	wire win_any = win_sel != 3'h0;
	wire ebu_fcfg_t sel_fcfg = win_any ? WINDOW_FUNCTION_CONFIG_IN[win_sel] : DEFAULT_FUNCTION_CONFIG_IN;
	wire ebu_tcfg_t sel_tcfg = win_any ? WINDOW_TIMING_CONFIG_IN[win_sel] : DEFAULT_TIMING_CONFIG_IN;

	// Area decode.
	wire req_io = REQ_ADDR_IN[23:21] == `EBU_IO_AREA_TOP;
	wire req_pb = (REQ_ADDR_IN[23:16] == `EBU_PB_SEGMENT) && ((REQ_ADDR_IN[15:14] == `EBU_PB_CAN_TOP)
		|| (REQ_ADDR_IN[15:13] == `EBU_PB_SER_TOP) || (REQ_ADDR_IN[15:14] == `EBU_PB_ALT_TOP));

	// The bus moves only when the reference clock is about to rise.
	wire tick = !ref_clk_r;
	wire accept = REQ_VALID_IN && REQ_READY_OUT;
	assign REQ_READY_OUT = (state_r == ST_IDLE) && tick && rst_n;

	wire rdy_ok = !fcfg_r[`EBU_FC_RDY_EN] || (ready_s == fcfg_r[`EBU_FC_RDY_POL]);
	// The access being taken drives its address phase before its registers have loaded.
	wire ebu_fcfg_t cur_fcfg = accept ? sel_fcfg : fcfg_r;
	wire ebu_addr_t cur_addr = accept ? REQ_ADDR_IN : addr_r;
	wire [2:0] cur_win = accept ? win_sel : win_r;
	wire cur_word = accept ? REQ_WORD_IN : word_r;
	wire wide = cur_fcfg[`EBU_FC_WIDE];
	wire muxed = cur_fcfg[`EBU_FC_MUX];
	wire split = cur_word && !wide;
	wire last_step = !split || second_r;
	wire posted = REQ_WRITE_IN && !req_io && !req_pb;

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
				if (accept)
				begin
					if (req_pb)
						state_nxt = ST_PB;
					else if (!SINGLE_CHIP_IN)
						state_nxt = ST_ADDR;
				end
			ST_ADDR:
				if (tick)
					state_nxt = ST_CMD;
			ST_CMD:
				if (tick && wcnt_r == 4'h0 && rdy_ok)
					state_nxt = ST_HOLD;
			ST_HOLD:
				if (tick)
					state_nxt = last_step ? ST_IDLE : ST_ADDR;
			ST_PB:
				if (PB_READY_IN)
					state_nxt = ST_IDLE;
			default:
				state_nxt = ST_IDLE;
		endcase
	end

	// Effective address limit from width and segment lines.
	wire [4:0] aw_req = (ADDR_WIDTH_IN > `EBU_ADDR_MAX) ? `EBU_ADDR_MAX : ADDR_WIDTH_IN;
	wire [4:0] aw_seg = `EBU_SEG_BASE + {2'h0, SEG_LINES_IN};
	wire [4:0] aw = (aw_req < aw_seg) ? aw_req : aw_seg;
	always_comb
	begin
		for (int i = 0; i < 24; i++)
			addr_mask[i] = 5'(i) < aw;
	end

	wire addr_step = (split && state_r == ST_HOLD) || (second_r && state_r != ST_IDLE);
	wire [23:0] bus_addr = {cur_addr[23:1], cur_addr[0] | addr_step} & addr_mask;
	wire ext_on = (state_nxt == ST_ADDR) || (state_nxt == ST_CMD) || (state_nxt == ST_HOLD);
	wire ale_nxt = state_nxt == ST_ADDR;
	wire strobe_nxt = state_nxt == ST_CMD;
	wire [7:0] byte_out = (split && second_r) || (!wide && addr_r[0]) ? wdata_r[15:8] : wdata_r[7:0];
	wire [15:0] wr_word = wide ? (word_r ? wdata_r : {wdata_r[7:0], wdata_r[7:0]}) : {8'h00, byte_out};
	wire [15:0] lane_oe = wide ? 16'hFFFF : 16'h00FF;
	wire drive_data = write_r && (strobe_nxt || state_nxt == ST_HOLD);
	wire drive_addr = ale_nxt && muxed;
	wire [15:0] ad_nxt = drive_addr ? bus_addr[15:0] : (drive_data ? wr_word : 16'h0000);
	wire [15:0] ad_oe_nxt = drive_addr ? addr_mask[15:0] : (drive_data ? lane_oe : 16'h0000);
	wire hi_byte = wide && (cur_word || cur_addr[0]);
	wire [4:0] cs_sel = 5'h01 << cur_win;
	wire [4:0] cs_n_nxt = (ext_on && cur_fcfg[`EBU_FC_CS_EN] && !SINGLE_CHIP_IN) ? ~cs_sel : `EBU_RESET_CS;

	// Access bookkeeping.
	always_ff @(posedge REF_CLK_IN or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= ST_IDLE;
			addr_r <= 24'h000000;
			wdata_r <= `EBU_RESET_DATA;
			write_r <= 1'b0;
			word_r <= 1'b0;
			io_r <= 1'b0;
			win_r <= 3'h0;
			fcfg_r <= 6'h00;
			tcfg_r <= 4'h0;
		end
		else
		begin
			state_r <= state_nxt;
			if (accept)
			begin
				addr_r <= REQ_ADDR_IN;
				wdata_r <= REQ_WDATA_IN;
				write_r <= REQ_WRITE_IN;
				word_r <= REQ_WORD_IN;
				io_r <= req_io;
				win_r <= win_sel;
				fcfg_r <= sel_fcfg;
				tcfg_r <= sel_tcfg;
			end
		end
	end

	// Wait counter and byte step of split accesses.
	always_ff @(posedge REF_CLK_IN or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wcnt_r <= 4'h0;
			second_r <= 1'b0;
		end
		else
		begin
			if (state_r == ST_ADDR && tick)
				wcnt_r <= tcfg_r;
			else if (state_r == ST_CMD && tick && wcnt_r != 4'h0)
				wcnt_r <= wcnt_r - 4'h1;
			if (accept)
				second_r <= 1'b0;
			else if (state_r == ST_HOLD && tick)
				second_r <= 1'b1;
		end
	end

	// Read capture and responses.
	wire ext_done = (state_r == ST_HOLD) && tick && last_step;
	wire pb_done = (state_r == ST_PB) && PB_READY_IN;
	always_ff @(posedge REF_CLK_IN or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata_r <= `EBU_RESET_DATA;
			rsp_valid_r <= 1'b0;
			rsp_err_r <= 1'b0;
		end
		else
		begin
			if (state_r == ST_CMD && state_nxt == ST_HOLD && !write_r)
			begin
				if (wide)
					rdata_r <= AD_IN;
				else if (second_r)
					rdata_r[15:8] <= AD_IN[7:0];
				else
					rdata_r <= {8'h00, AD_IN[7:0]};
			end
			else if (pb_done && !write_r)
				rdata_r <= PB_RDATA_IN;
			rsp_valid_r <= (accept && ((SINGLE_CHIP_IN && !req_pb) || posted)) || pb_done || (ext_done && (!write_r || io_r));
			rsp_err_r <= accept && SINGLE_CHIP_IN && !req_pb;
		end
	end

	// Reference clock and registered pins.
	always_ff @(posedge REF_CLK_IN or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ref_clk_r <= 1'b0;
			ad_r <= 16'h0000;
			ad_oe_r <= 16'h0000;
			a_lo_r <= 16'h0000;
			a_lo_oe_r <= 1'b0;
			a_hi_r <= 8'h00;
			a_hi_oe_r <= 8'h00;
			ale_r <= 1'b0;
			rd_n_r <= 1'b1;
			wr_n_r <= 1'b1;
			bhe_n_r <= 1'b1;
			cs_n_r <= `EBU_RESET_CS;
		end
		else
		begin
			ref_clk_r <= !ref_clk_r;
			if (tick)
			begin
				ad_r <= ad_nxt;
				ad_oe_r <= ad_oe_nxt;
				a_lo_r <= bus_addr[15:0];
				a_lo_oe_r <= ext_on && !muxed;
				a_hi_r <= bus_addr[23:16];
				a_hi_oe_r <= ext_on ? addr_mask[23:16] : 8'h00;
				ale_r <= ale_nxt;
				rd_n_r <= !(strobe_nxt && !write_r);
				wr_n_r <= !(strobe_nxt && write_r);
				bhe_n_r <= !(ext_on && hi_byte);
				cs_n_r <= cs_n_nxt;
			end
		end
	end

	assign BUS_REFERENCE_CLOCK_OUT = EXTERNAL_CLOCK_OUTPUT_SELECT_IN && ref_clk_r;
	assign CLOCK_PAD_ENABLE_OUT = EXTERNAL_CLOCK_OUTPUT_SELECT_IN;
	assign AD_OUT = ad_r;
	assign AD_OE_OUT = ad_oe_r;
	assign A_LO_OUT = a_lo_r;
	assign A_LO_OE_OUT = a_lo_oe_r;
	assign A_HI_OUT = a_hi_r;
	assign A_HI_OE_OUT = a_hi_oe_r;
	assign ALE_OUT = ale_r;
	assign RD_N_OUT = rd_n_r;
	assign WR_N_OUT = wr_n_r;
	assign BHE_N_OUT = bhe_n_r;
	assign CS_N_OUT = cs_n_r;
	assign RSP_VALID_OUT = rsp_valid_r;
	assign RSP_RDATA_OUT = rdata_r;
	assign RSP_ERR_OUT = rsp_err_r;
	assign PB_SEL_OUT = state_r == ST_PB;
	assign PB_WRITE_OUT = write_r;
	assign PB_WORD_OUT = word_r;
	assign PB_ADDR_OUT = addr_r[15:0];
	assign PB_WDATA_OUT = wdata_r;
	assign BUS_BUSY_OUT = state_r != ST_IDLE;
	assign ACTIVE_WINDOW_OUT = win_r;
endmodule : ebu_external_bus_unit
`default_nettype wire

/* bench/ebu_ext_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module ebu_ext_mem (
	// Bus side
	input wire logic clk_in,
	input wire logic ale_in,
	input wire logic rd_n_in,
	input wire logic wr_n_in,
	input wire logic bhe_n_in,
	input wire logic a_lo_oe_in,
	input wire logic [15:0] a_lo_in,
	input wire logic [15:0] ad_in,
	// Behaviour
	input wire logic slow_in,
	input wire logic pol_in,
	output logic [15:0] ad_out,
	output logic ready_out
);
	logic [7:0] mem [0:31];
	logic [4:0] a = 5'h00;
	logic [15:0] last = 16'h0000;
	logic [1:0] wcnt = 2'h0;
	logic lclk = 1'b0;
	wire idle = rd_n_in && wr_n_in;
	wire [15:0] rdv = a[0] ? {mem[a], mem[a]} : {mem[a | 5'h01], mem[a]};
	always #200 lclk = ~lclk;
	always @(posedge clk_in)
	begin
		if (ale_in)
			a <= a_lo_oe_in ? a_lo_in[4:0] : ad_in[4:0];
		if (!rd_n_in)
			last <= rdv;
		if (!wr_n_in)
			mem[a] <= ad_in[7:0];
		if (!wr_n_in && !a[0] && !bhe_n_in)
			mem[a | 5'h01] <= ad_in[15:8];
	end
	// A released bus shows the inverse of the last value, never a held copy.
	assign ad_out = rd_n_in ? ~last : rdv;
	always @(posedge lclk or posedge idle)
		wcnt <= idle ? 2'h0 : (wcnt == 2'h3 ? wcnt : wcnt + 2'h1);
	assign ready_out = pol_in ^ (slow_in && wcnt != 2'h3);
endmodule : ebu_ext_mem
`default_nettype wire

/* bench/ebu_external_bus_unit_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module ebu_bus_checker (
	input wire logic REF_CLK_IN,
	input wire logic RST_N_IN,
	input wire logic SINGLE_CHIP_IN,
	input wire logic EXTERNAL_CLOCK_OUTPUT_SELECT_IN,
	input wire logic REQ_VALID_IN,
	input wire logic REQ_READY_OUT,
	input wire ebu_pkg::ebu_addr_t REQ_ADDR_IN,
	input wire logic RSP_VALID_OUT,
	input wire logic RSP_ERR_OUT,
	input wire logic PB_SEL_OUT,
	input wire logic PB_READY_IN,
	input wire logic [15:0] AD_OE_OUT,
	input wire logic A_LO_OE_OUT,
	input wire logic [7:0] A_HI_OUT,
	input wire logic ALE_OUT,
	input wire logic RD_N_OUT,
	input wire logic [4:0] CS_N_OUT,
	input wire logic BUS_REFERENCE_CLOCK_OUT,
	input wire logic CLOCK_PAD_ENABLE_OUT,
	input wire logic BUS_BUSY_OUT
);
	default clocking dcb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	a_single_err: assert property (SINGLE_CHIP_IN && REQ_VALID_IN && REQ_READY_OUT && REQ_ADDR_IN[23:16] != 8'h20
		|=> RSP_VALID_OUT && RSP_ERR_OUT) else $error("single-chip access not refused");
	a_idle_cs: assert property (!BUS_BUSY_OUT || SINGLE_CHIP_IN |-> CS_N_OUT == 5'h1F)
		else $error("chip select active while idle");
	a_cs_onehot: assert property ($onehot0(~CS_N_OUT))
		else $error("several chip selects active");
	a_rd_stable: assert property (!RD_N_OUT && !$past(RD_N_OUT) |-> $stable(CS_N_OUT) && $stable(A_HI_OUT))
		else $error("address or select moved during strobe");
	a_pin_edge: assert property (EXTERNAL_CLOCK_OUTPUT_SELECT_IN && $changed(RD_N_OUT)
		|-> $rose(BUS_REFERENCE_CLOCK_OUT)) else $error("strobe moved off reference edge");
	a_ref_clock: assert property (!EXTERNAL_CLOCK_OUTPUT_SELECT_IN [*2]
		|-> !BUS_REFERENCE_CLOCK_OUT && !CLOCK_PAD_ENABLE_OUT) else $error("reference clock not gated");
	a_pb_resp: assert property (PB_SEL_OUT && PB_READY_IN |=> RSP_VALID_OUT)
		else $error("peripheral answer not passed on");
	a_mux_addr: assert property (ALE_OUT && !A_LO_OE_OUT |-> AD_OE_OUT[7:0] == 8'hFF)
		else $error("multiplexed address not driven");
endmodule : ebu_bus_checker
bind ebu_external_bus_unit ebu_bus_checker chk_i (.*);
`default_nettype wire

/* bench/ebu_external_bus_unit_test.sv */
`timescale 1ns/10ps
`default_nettype none
module ebu_external_bus_unit_test;
	import ebu_pkg::*;
	logic REF_CLK_IN = 1'b0, RST_N_IN = 1'b0, SINGLE_CHIP_IN = 1'b0, EXTERNAL_CLOCK_OUTPUT_SELECT_IN = 1'b1;
	logic [4:0] ADDR_WIDTH_IN = 5'h18;
	logic [2:0] SEG_LINES_IN = 3'h7;
	logic [4:1][15:0] WINDOW_ADDRESS_SELECT_IN = {4{16'h0010}};
	logic [4:1][5:0] WINDOW_FUNCTION_CONFIG_IN = '0;
	logic [4:1][3:0] WINDOW_TIMING_CONFIG_IN = '0;
	ebu_fcfg_t DEFAULT_FUNCTION_CONFIG_IN = 6'h1E;
	ebu_tcfg_t DEFAULT_TIMING_CONFIG_IN = 4'h1;
	logic REQ_VALID_IN = 1'b0, REQ_WRITE_IN = 1'b0, REQ_WORD_IN = 1'b0, PB_READY_IN = 1'b0, slow = 1'b0, pol = 1'b1;
	ebu_addr_t REQ_ADDR_IN = 24'h000000;
	ebu_data_t REQ_WDATA_IN = 16'h0000, PB_RDATA_IN = 16'h5A5A, RSP_RDATA_OUT, PB_WDATA_OUT;
	logic REQ_READY_OUT, RSP_VALID_OUT, RSP_ERR_OUT, PB_SEL_OUT, PB_WRITE_OUT, PB_WORD_OUT, A_LO_OE_OUT, ALE_OUT;
	logic RD_N_OUT, WR_N_OUT, BHE_N_OUT, BUS_REFERENCE_CLOCK_OUT, CLOCK_PAD_ENABLE_OUT, BUS_BUSY_OUT, READY_IN;
	logic [15:0] PB_ADDR_OUT, AD_OUT, AD_OE_OUT, A_LO_OUT, mem_d;
	logic [7:0] A_HI_OUT, A_HI_OE_OUT;
	logic [4:0] CS_N_OUT;
	logic [2:0] ACTIVE_WINDOW_OUT;
	wire [15:0] AD_IN = (AD_OE_OUT & AD_OUT) | (~AD_OE_OUT & mem_d);
	int err_count = 0;
	int comparisons = 0;
	int cyc;
	ebu_external_bus_unit uut (.*);
	ebu_ext_mem mem_i (.clk_in(REF_CLK_IN), .ale_in(ALE_OUT), .rd_n_in(RD_N_OUT), .wr_n_in(WR_N_OUT),
		.bhe_n_in(BHE_N_OUT), .a_lo_oe_in(A_LO_OE_OUT), .a_lo_in(A_LO_OUT), .ad_in(AD_IN), .slow_in(slow),
		.pol_in(pol), .ad_out(mem_d), .ready_out(READY_IN));
	always #25 REF_CLK_IN = ~REF_CLK_IN;
	always @(posedge REF_CLK_IN) PB_READY_IN <= PB_SEL_OUT && !PB_READY_IN;
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		comparisons++;
		if (s !== e)
		begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic acc(input ebu_addr_t a, input logic w, input logic k, input ebu_data_t d);
		REQ_ADDR_IN <= a;
		REQ_WRITE_IN <= w;
		REQ_WORD_IN <= k;
		REQ_WDATA_IN <= d;
		REQ_VALID_IN <= 1'b1;
		cyc = 0;
		do @(posedge REF_CLK_IN); while (REQ_READY_OUT !== 1'b1 && ++cyc < 200);
		REQ_VALID_IN <= 1'b0;
		cyc = 0;
		do @(posedge REF_CLK_IN); while (RSP_VALID_OUT !== 1'b1 && ++cyc < 300);
		chk("rsp_valid", 16'(RSP_VALID_OUT), 16'h0001);
	endtask : acc
	task automatic t_single;
		SINGLE_CHIP_IN <= 1'b1;
		@(posedge REF_CLK_IN);
		acc(24'h000100, 1'b0, 1'b1, 16'h0000);
		chk("rsp_err", 16'(RSP_ERR_OUT), 16'h0001);
		chk("cs_n", 16'(CS_N_OUT), 16'h001F);
		SINGLE_CHIP_IN <= 1'b0;
	endtask : t_single
	task automatic t_default;
		acc(24'h000010, 1'b1, 1'b1, 16'hA55A);
		acc(24'h000013, 1'b1, 1'b0, 16'h3C3C);
		acc(24'h000010, 1'b0, 1'b1, 16'h0000);
		chk("rdata", RSP_RDATA_OUT, 16'hA55A);
		acc(24'h000012, 1'b0, 1'b1, 16'h0000);
		chk("rdata_hi", 16'(RSP_RDATA_OUT[15:8]), 16'h003C);
		chk("window", 16'(ACTIVE_WINDOW_OUT), 16'h0000);
		SEG_LINES_IN <= 3'h0;
		acc(24'h210018, 1'b1, 1'b1, 16'h0F0F);
		chk("io_wait", 16'(cyc > 4), 16'h0001);
		chk("a_hi", 16'(A_HI_OUT), 16'h0000);
		SEG_LINES_IN <= 3'h7;
	endtask : t_default
	task automatic t_windows;
		for (int k = 1; k <= 4; k++)
		begin
			WINDOW_FUNCTION_CONFIG_IN[k] <= k[0] ? 6'h3D : 6'h3E;
			@(posedge REF_CLK_IN);
			acc(24'h001000 + 24'(2 * k), 1'b1, 1'b1, 16'h1230 + 16'(k));
			acc(24'h001000 + 24'(2 * k), 1'b0, 1'b1, 16'h0000);
			chk("win_data", RSP_RDATA_OUT, 16'h1230 + 16'(k));
			chk("window", 16'(ACTIVE_WINDOW_OUT), 16'(k));
		end
	endtask : t_windows
	task automatic t_slow;
		WINDOW_FUNCTION_CONFIG_IN[4] <= 6'h2E;
		pol <= 1'b0;
		slow <= 1'b1;
		@(posedge REF_CLK_IN);
		acc(24'h001008, 1'b0, 1'b1, 16'h0000);
		chk("slow_data", RSP_RDATA_OUT, 16'h1234);
		chk("slow_wait", 16'(cyc > 12), 16'h0001);
		slow <= 1'b0;
	endtask : t_slow
	task automatic t_periph;
		acc(24'h204000, 1'b0, 1'b1, 16'h0000);
		chk("pb_data", RSP_RDATA_OUT, 16'h5A5A);
		chk("pb_addr", PB_ADDR_OUT, 16'h4000);
		chk("pb_word", 16'(PB_WORD_OUT), 16'h0001);
		EXTERNAL_CLOCK_OUTPUT_SELECT_IN <= 1'b0;
		repeat (4) @(posedge REF_CLK_IN);
		chk("pad", 16'(CLOCK_PAD_ENABLE_OUT), 16'h0000);
		EXTERNAL_CLOCK_OUTPUT_SELECT_IN <= 1'b1;
	endtask : t_periph
	task automatic close_out;
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out
	initial
	begin
		repeat (6) @(posedge REF_CLK_IN);
		RST_N_IN <= 1'b1;
		repeat (6) @(posedge REF_CLK_IN);
		chk("cs_idle", 16'(CS_N_OUT), 16'h001F);
		t_single();
		t_default();
		t_windows();
		t_slow();
		t_periph();
		close_out();
	end
	initial
	begin
		#500000;
		err_count++;
		close_out();
	end
endmodule : ebu_external_bus_unit_test
`default_nettype wire
